// >>> shared/lcd_bias_pkg.sv
// constants for the segment lcd bias and waveform control block
// Overview of operation
// - quick charge lasts code plus one periods
// - quick charge counts low-speed source clock periods
// - ratio codes give 8..15/16, 1xxx full
// - control bit 4 reads zero, ignores writes
// - capacitor bias turns charge pump on while display is on
// - quarter duty, four commons, four slots
// - wave type picks type a or b
// - polarity alternates, net pixel dc zero
// - bias kind 0 resistor, 1 capacitor
// - sleep mode always blanks the display
// - lcd clock is source clock over eight
package lcd_bias_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_BIAS_CHARGE = 8'h00;
  localparam logic [7:0] OFS_WAVE_CTRL   = 8'h04;
  localparam logic [7:0] OFS_STATUS      = 8'h08;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int QCT_LSB      = 5;
  localparam int QCT_MSB      = 7;
  localparam int RATIO_MSB    = 3;
  localparam int EN_BIT       = 0;
  localparam int KIND_BIT     = 6;
  localparam int TYPE_BIT     = 7;
  localparam logic [7:0] BIAS_CHARGE_RST = 8'h00;
  localparam logic [7:0] BIAS_CHARGE_WMASK = 8'hef;
  localparam logic [7:0] WAVE_CTRL_RST   = 8'h00;
  localparam logic [7:0] WAVE_CTRL_WMASK = 8'hc1;

  // ----------------------------------------------------------------
  // geometry and timing
  // ----------------------------------------------------------------
  localparam int NUM_COM      = 4;
  localparam int NUM_SEG      = 56;
  localparam logic [2:0] LCD_DIV_LAST = 3'h7;
  localparam logic [4:0] RATIO_BASE   = 5'h08;
  localparam logic [4:0] RATIO_FULL   = 5'h10;

  // output level codes for the 1/3 bias ladder
  localparam logic [1:0] LVL_VSS = 2'h0;
  localparam logic [1:0] LVL_VC  = 2'h1;
  localparam logic [1:0] LVL_VB  = 2'h2;
  localparam logic [1:0] LVL_VA  = 2'h3;

endpackage

// >>> logic/lcd_bias_and_wave_control.sv
// segment lcd bias and waveform control with an ahb-lite register slave
`timescale 1ns/100ps
module lcd_bias_and_wave_control
(
  input  wire logic                              hclk,
  input  wire logic                              hresetn,
  input  wire logic                              hsel,
  input  wire logic [31:0]                       haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic [31:0]                       hwdata,
  input  wire logic                              hready,
  output logic      [31:0]                       hrdata,
  output logic                                   hreadyout,
  output logic                                   hresp,
  input  wire logic                              src_clk_tick,
  input  wire logic                              sleep_mode,
  input  wire logic [lcd_bias_pkg::NUM_SEG*4-1:0] seg_pixels,
  output logic      [lcd_bias_pkg::NUM_COM*2-1:0] com_level,
  output logic      [lcd_bias_pkg::NUM_SEG*2-1:0] seg_level,
  output logic                                   pump_enable,
  output logic                                   quick_charge,
  output logic      [4:0]                        top_ratio_sixteenths
);

  // ----------------------------------------------------------------
  // state declarations
  // ----------------------------------------------------------------
  logic [7:0]  bias_charge_r, bias_charge_nxt;
  logic [7:0]  wave_ctrl_r, wave_ctrl_nxt;
  logic        wr_pend_r, wr_pend_nxt;
  logic [7:0]  wr_addr_r, wr_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [2:0]  div_r, div_nxt;
  logic [2:0]  phase_r, phase_nxt;
  logic [2:0]  qc_cnt_r, qc_cnt_nxt;
  logic        qc_r, qc_nxt;
  logic        lcd_tick;
  logic        display_on;
  logic [1:0]  slot;
  logic        pol;
  logic [2:0]  quick_code;
  logic        bias_kind_sel;
  logic        wave_type_b;
  logic        display_enable_bit;

  assign quick_code         = bias_charge_r[lcd_bias_pkg::QCT_MSB:lcd_bias_pkg::QCT_LSB];
  assign bias_kind_sel      = wave_ctrl_r[lcd_bias_pkg::KIND_BIT];
  assign wave_type_b        = wave_ctrl_r[lcd_bias_pkg::TYPE_BIT];
  assign display_enable_bit = wave_ctrl_r[lcd_bias_pkg::EN_BIT];

  // ----------------------------------------------------------------
  // ahb-lite register slave, zero wait states
  // ----------------------------------------------------------------
  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      lcd_bias_pkg::OFS_BIAS_CHARGE: v[7:0] = bias_charge_r & lcd_bias_pkg::BIAS_CHARGE_WMASK;
      lcd_bias_pkg::OFS_WAVE_CTRL:   v[7:0] = wave_ctrl_r;
      lcd_bias_pkg::OFS_STATUS:      v[7:0] = {2'h0, qc_r, pump_enable, display_on, phase_r};
      default:                       v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // decode address phase, write in data phase, read data staged early
  always_comb
  begin
    wr_pend_nxt     = 1'b0;
    wr_addr_nxt     = wr_addr_r;
    hrdata_nxt      = hrdata_r;
    bias_charge_nxt = bias_charge_r;
    wave_ctrl_nxt   = wave_ctrl_r;
    if (wr_pend_r)
    begin
      if (wr_addr_r == lcd_bias_pkg::OFS_BIAS_CHARGE)
        bias_charge_nxt = hwdata[7:0] & lcd_bias_pkg::BIAS_CHARGE_WMASK;
      if (wr_addr_r == lcd_bias_pkg::OFS_WAVE_CTRL)
        wave_ctrl_nxt = hwdata[7:0] & lcd_bias_pkg::WAVE_CTRL_WMASK;
    end
    if (hsel && htrans[1] && hready)
    begin
      wr_pend_nxt = hwrite;
      wr_addr_nxt = haddr[7:0];
      if (!hwrite)
        hrdata_nxt = read_word(haddr[7:0]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bias_charge_r <= lcd_bias_pkg::BIAS_CHARGE_RST;
      wave_ctrl_r   <= lcd_bias_pkg::WAVE_CTRL_RST;
      wr_pend_r     <= 1'b0;
      wr_addr_r     <= 8'h00;
      hrdata_r      <= 32'h0000_0000;
    end
    else
    begin
      bias_charge_r <= bias_charge_nxt;
      wave_ctrl_r   <= wave_ctrl_nxt;
      wr_pend_r     <= wr_pend_nxt;
      wr_addr_r     <= wr_addr_nxt;
      hrdata_r      <= hrdata_nxt;
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------
  // lcd clock divider, frame phase and quick charge timer
  // ----------------------------------------------------------------
  assign display_on = display_enable_bit && !sleep_mode;
  assign lcd_tick   = src_clk_tick && (div_r == lcd_bias_pkg::LCD_DIV_LAST);

  // phase steps once per lcd clock; quick charge restarts at each step under resistor bias only
  always_comb
  begin
    div_nxt    = div_r;
    phase_nxt  = phase_r;
    qc_nxt     = qc_r;
    qc_cnt_nxt = qc_cnt_r;
    if (src_clk_tick)
      div_nxt = div_r + 3'h1;
    if (!display_on)
    begin
      phase_nxt = 3'h0;
      qc_nxt    = 1'b0;
    end
    else if (lcd_tick)
    begin
      phase_nxt  = phase_r + 3'h1;
      qc_nxt     = !bias_kind_sel; // resistor bias only
      qc_cnt_nxt = quick_code;
    end
    else if (qc_r && src_clk_tick)
    begin
      if (qc_cnt_r == 3'h0)
        qc_nxt = 1'b0;
      else
        qc_cnt_nxt = qc_cnt_r - 3'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_r    <= 3'h0;
      phase_r  <= 3'h0;
      qc_r     <= 1'b0;
      qc_cnt_r <= 3'h0;
    end
    else
    begin
      div_r    <= div_nxt;
      phase_r  <= phase_nxt;
      qc_r     <= qc_nxt;
      qc_cnt_r <= qc_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // bias selection outputs
  // ----------------------------------------------------------------
  assign quick_charge = qc_r;
  assign pump_enable  = display_on && bias_kind_sel;
  assign top_ratio_sixteenths = bias_charge_r[lcd_bias_pkg::RATIO_MSB] ?
                                lcd_bias_pkg::RATIO_FULL :
                                lcd_bias_pkg::RATIO_BASE + {2'h0, bias_charge_r[2:0]};

  // ----------------------------------------------------------------
  // waveform generation
  // ----------------------------------------------------------------
  // type a flips polarity inside every slot, type b once per frame
  assign slot = wave_type_b ? phase_r[1:0] : phase_r[2:1];
  assign pol  = wave_type_b ? phase_r[2]   : phase_r[0];

  logic [lcd_bias_pkg::NUM_COM*2-1:0] com_nxt, com_r;
  logic [lcd_bias_pkg::NUM_SEG*2-1:0] seg_nxt, seg_r;

  genvar gi;
  generate
    for (gi = 0; gi < lcd_bias_pkg::NUM_COM; gi++)
    begin : g_com
      // selected common swings to the outer levels, the others stay inside
      assign com_nxt[gi*2 +: 2] =
        !display_on      ? lcd_bias_pkg::LVL_VSS :
        (slot == 2'(gi)) ? (pol ? lcd_bias_pkg::LVL_VSS : lcd_bias_pkg::LVL_VA) :
        (pol ? lcd_bias_pkg::LVL_VB : lcd_bias_pkg::LVL_VC);
    end
    for (gi = 0; gi < lcd_bias_pkg::NUM_SEG; gi++)
    begin : g_seg
      // lit pixels take the outer level opposite to their common
      assign seg_nxt[gi*2 +: 2] =
        !display_on            ? lcd_bias_pkg::LVL_VSS :
        seg_pixels[gi*4+slot] ? (pol ? lcd_bias_pkg::LVL_VA : lcd_bias_pkg::LVL_VSS) :
        (pol ? lcd_bias_pkg::LVL_VC : lcd_bias_pkg::LVL_VB);
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      com_r <= '0;
      seg_r <= '0;
    end
    else
    begin
      com_r <= com_nxt;
      seg_r <= seg_nxt;
    end
  end

  assign com_level = com_r;
  assign seg_level = seg_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_bit4_zero;
    @(posedge hclk) disable iff (!hresetn)
    (hsel && htrans[1] && hready && !hwrite && haddr[7:0] == lcd_bias_pkg::OFS_BIAS_CHARGE)
      |=> hrdata_r[4] == 1'b0;
  endproperty
  a_bit4_zero: assert property (p_bit4_zero) else $error("control bit 4 read nonzero");

  property p_pump;
    @(posedge hclk) disable iff (!hresetn)
    pump_enable == (bias_kind_sel && !sleep_mode && display_enable_bit);
  endproperty
  a_pump: assert property (p_pump) else $error("pump enable wrong");

  property p_kind;
    @(posedge hclk) disable iff (!hresetn)
    $rose(qc_r) |-> !$past(bias_kind_sel);
  endproperty
  a_kind: assert property (p_kind) else $error("quick charge under capacitor bias");

  property p_sleep;
    @(posedge hclk) disable iff (!hresetn)
    sleep_mode |=> com_r == '0 && phase_r == 3'h0;
  endproperty
  a_sleep: assert property (p_sleep) else $error("display active in sleep");

  property p_ratio;
    @(posedge hclk) disable iff (!hresetn)
    bias_charge_r[3] |-> top_ratio_sixteenths == 5'h10;
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio top bit not full");

  property p_div;
    @(posedge hclk) disable iff (!hresetn)
    (display_on && src_clk_tick) |=>
      phase_r == (($past(div_r) == lcd_bias_pkg::LCD_DIV_LAST) ? $past(phase_r) + 3'h1
                                                                : $past(phase_r));
  endproperty
  a_div: assert property (p_div) else $error("phase not stepped on eighth tick");

  property p_qc_len;
    @(posedge hclk) disable iff (!hresetn)
    (qc_r && src_clk_tick && !lcd_tick && qc_cnt_r == 3'h0 && display_on) |=> !qc_r;
  endproperty
  a_qc_len: assert property (p_qc_len) else $error("quick charge overran");

  property p_qc_src;
    @(posedge hclk) disable iff (!hresetn)
    (qc_r && !src_clk_tick && !lcd_tick && display_on) |=> $stable(qc_cnt_r) && qc_r;
  endproperty
  a_qc_src: assert property (p_qc_src) else $error("quick charge counted hclk");

  property p_one_com;
    @(posedge hclk) disable iff (!hresetn)
    (display_on && !pol) |=> $onehot({com_r[7:6] == lcd_bias_pkg::LVL_VA,
                                      com_r[5:4] == lcd_bias_pkg::LVL_VA,
                                      com_r[3:2] == lcd_bias_pkg::LVL_VA,
                                      com_r[1:0] == lcd_bias_pkg::LVL_VA});
  endproperty
  a_one_com: assert property (p_one_com) else $error("not one common selected");

endmodule

// >>> sim/lcd_panel_model.sv
// behavioural glass that sums pixel drive over each display phase
`timescale 1ns/100ps
module lcd_panel_model
(
  hclk,
  clear,
  com_level,
  seg_level,
  dc_on,
  dc_off
);
  input  wire logic         hclk;
  input  wire logic         clear;
  input  wire logic [7:0]   com_level;
  input  wire logic [111:0] seg_level;
  output int                dc_on;
  output int                dc_off;

  logic [7:0] last_com;

  // add common minus segment of two pixels of common 0 at each new phase
  always @(posedge hclk)
  begin
    last_com <= com_level;
    if (clear)
    begin
      dc_on <= 0;
      dc_off <= 0;
    end
    else if (com_level !== last_com)
    begin
      dc_on <= dc_on + int'(com_level[1:0]) - int'(seg_level[1:0]);
      dc_off <= dc_off + int'(com_level[1:0]) - int'(seg_level[3:2]);
    end
  end
endmodule

// >>> sim/testbench.sv
// self-checking bench for the lcd bias and waveform control block
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %0t mismatch got %0h exp %0h", $time, g, e); end end
module testbench;
  logic         hclk, hresetn, hsel, hwrite, src_clk_tick, sleep_mode;
  logic         hreadyout, hresp, pump_enable, quick_charge, clear, chk_sel, qc_d;
  logic [31:0]  haddr, hwdata, hrdata, rdv;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [4:0]   top_ratio_sixteenths;
  logic [223:0] seg_pixels;
  logic [7:0]   com_level, com_q;
  logic [111:0] seg_level;
  int           n_fail, samples_checked, n_chg, n_c0, n_sel, qc_cnt, qc_len, dc_on, dc_off;

  lcd_bias_and_wave_control dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .src_clk_tick,
    .sleep_mode, .seg_pixels, .com_level, .seg_level, .pump_enable, .quick_charge,
    .top_ratio_sixteenths);
  lcd_panel_model panel_u (.hclk, .clear, .com_level, .seg_level, .dc_on, .dc_off);

  // clock of 4 ns
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // phase changes, one selected common per slot, charge length in ticks
  always @(posedge hclk)
  begin
    com_q <= com_level;
    qc_d <= quick_charge;
    if (quick_charge === 1'b1 && src_clk_tick === 1'b1)
      qc_cnt++;
    if (qc_d === 1'b1 && quick_charge === 1'b0)
    begin
      qc_len = qc_cnt;
      qc_cnt = 0;
    end
    if (clear)
    begin
      n_chg = 0;
      n_c0 = 0;
    end
    else if (chk_sel && com_level !== com_q)
    begin
      n_chg++;
      n_c0 += (com_level[1:0] !== com_q[1:0]);
      n_sel = 0;
      for (int k = 0; k < 4; k++)
        n_sel += (com_level[2*k+:2] inside {lcd_bias_pkg::LVL_VA, lcd_bias_pkg::LVL_VSS});
      `CHK(n_sel, 1)
    end
  end

  // verdict and end of run
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // wait for the sampling edge with hready high, bounded
  task wait_rdy;
    int i;
    for (i = 0; i < 50; i++)
    begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        break;
    end
    if (i == 50)
    begin
      n_fail++;
      finish_test();
    end
  endtask

  // one single word transfer: address phase, then data phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rdv = hrdata;
    #1;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rdv, e)
    `CHK(hresp, 1'b0)
  endtask

  // source clock pulses, one every five system cycles
  task ticks(input int n);
    repeat (n)
    begin
      @(posedge hclk);
      src_clk_tick <= 1'b1;
      @(posedge hclk);
      src_clk_tick <= 1'b0;
      repeat (3) @(posedge hclk);
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {hresetn, hsel, hwrite, src_clk_tick, sleep_mode, clear, chk_sel} = '0;
    {haddr, hwdata, htrans, hsize, qc_cnt, qc_len} = '0;
    seg_pixels = 224'h1;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h0c, 32'h0);
    bus(1'b1, 8'h00, 32'hffff_ffff);
    rd_chk(8'h00, 32'h0000_00ef);
    for (int c = 0; c < 16; c++)
    begin
      bus(1'b1, 8'h00, c);
      `CHK(top_ratio_sixteenths, 5'(c < 8 ? c + 8 : 16))
    end
    $display("registers done");
    bus(1'b1, 8'h04, 32'h41);
    `CHK(pump_enable, 1'b1)
    bus(1'b1, 8'h04, 32'h01);
    `CHK(pump_enable, 1'b0)
    for (int c = 0; c < 7; c += 3)
    begin
      bus(1'b1, 8'h00, c << 5);
      ticks(24);
      `CHK(qc_len, c + 1)
    end
    $display("bias done");
    chk_sel <= 1'b1;
    for (int t = 0; t < 2; t++)
    begin
      bus(1'b1, 8'h04, t ? 32'h81 : 32'h01);
      ticks(8);
      clear <= 1'b1;
      @(posedge hclk);
      clear <= 1'b0;
      ticks(64);
      `CHK(n_chg, 8)
      `CHK(n_c0, t ? 4 : 8)
      `CHK(dc_on, 0)
      `CHK(dc_off, 0)
    end
    chk_sel <= 1'b0;
    sleep_mode <= 1'b1;
    ticks(8);
    `CHK(com_level, 8'h00)
    `CHK(seg_level, 112'h0)
    rd_chk(8'h08, 32'h0);
    $display("waveforms done");
    finish_test();
  end
endmodule
